//--- hw/acc_alu_map.vh
// Command codes, bank and port selectors and status values of the accumulator unit
`ifndef ACC_ALU_MAP_VH
`define ACC_ALU_MAP_VH
`define ACC_INS_GET_INPUT 8'h0f
`define ACC_INS_ACC_OP    8'h13
`define ACC_INS_COMPARE   8'h14
`define ACC_BANK_DIGITAL  8'h00
`define ACC_BANK_ANALOG   8'h01
`define ACC_BANK_OUTPUTS  8'h02
`define ACC_PORT_ALL      8'hff
`define ACC_PORT_ENC_ZERO 8'h0b
`define ACC_PORT_SUPPLY   8'h08
`define ACC_PORT_TEMP     8'h09
`define ACC_OP_ADD  4'h0
`define ACC_OP_SUB  4'h1
`define ACC_OP_MUL  4'h2
`define ACC_OP_DIV  4'h3
`define ACC_OP_MOD  4'h4
`define ACC_OP_AND  4'h5
`define ACC_OP_OR   4'h6
`define ACC_OP_XOR  4'h7
`define ACC_OP_NOT  4'h8
`define ACC_OP_LOAD 4'h9
`define ACC_ST_OK        8'h64
`define ACC_ST_BAD_TYPE  8'h03
`define ACC_ST_BAD_VALUE 8'h04
`define ACC_ST_BAD_CMD   8'h02
`define ACC_ACC_RESET    32'h00000000
`define ACC_DIV_STEPS    6'h20
`endif

//--- hw/acc_divider.v
// Sequential signed divider giving quotient and remainder
`timescale 1ns/1ps
`include "acc_alu_map.vh"
module acc_divider #(
  parameter W = 32
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         start,
  input  wire [W-1:0] dividend,
  input  wire [W-1:0] divisor,
  output reg          done,
  output reg  [W-1:0] quotient,
  output reg  [W-1:0] remainder
);
  reg         busy;
  reg [5:0]   count;
  reg [W-1:0] quo;
  reg [W-1:0] rem;
  reg [W-1:0] dvs;
  reg         neg_q;
  reg         neg_r;
  wire [W-1:0] abs_a = dividend[W-1] ? (~dividend + 1'b1) : dividend;
  wire [W-1:0] abs_b = divisor[W-1] ? (~divisor + 1'b1) : divisor;
  wire [W:0]   trial = {rem, quo[W-1]} - {1'b0, dvs};

  // Restoring division, one bit per cycle; sign fixed at the end so
  // the quotient truncates toward zero and remainder follows dividend
  always @(posedge clk) begin
    if (!rst_n) begin
      busy      <= 1'b0;
      done      <= 1'b0;
      count     <= 6'h00;
      quo       <= {W{1'b0}};
      rem       <= {W{1'b0}};
      dvs       <= {W{1'b0}};
      neg_q     <= 1'b0;
      neg_r     <= 1'b0;
      quotient  <= {W{1'b0}};
      remainder <= {W{1'b0}};
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy  <= 1'b1;
        count <= `ACC_DIV_STEPS;
        quo   <= abs_a;
        rem   <= {W{1'b0}};
        dvs   <= abs_b;
        neg_q <= dividend[W-1] ^ divisor[W-1];
        neg_r <= dividend[W-1];
      end else if (busy) begin
        if (count == 6'h00) begin
          busy      <= 1'b0;
          done      <= 1'b1;
          quotient  <= neg_q ? (~quo + 1'b1) : quo;
          remainder <= neg_r ? (~rem + 1'b1) : rem;
        end else begin
          count <= count - 6'h01;
          if (!trial[W]) begin
            rem <= trial[W-1:0];
            quo <= {quo[W-2:0], 1'b1};
          end else begin
            rem <= {rem[W-2:0], quo[W-1]};
            quo <= {quo[W-2:0], 1'b0};
          end
        end
      end
    end
  end
endmodule

//--- hw/acc_alu.v
// Accumulator unit: input readback, arithmetic operations and compare
`timescale 1ns/1ps
`include "acc_alu_map.vh"
module acc_alu #(
  parameter ADC_W = 12
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             cmd_valid,
  input  wire [7:0]       cmd_instr,
  input  wire [7:0]       cmd_type,
  input  wire [7:0]       cmd_bank,
  input  wire [31:0]      cmd_value,
  input  wire             standalone,
  input  wire [3:0]       general_input,
  input  wire [ADC_W-1:0] analog_input_0,
  input  wire [15:0]      supply_tenths,
  input  wire [15:0]      temperature_c,
  input  wire             encoder_near_zero,
  input  wire [1:0]       digital_output,
  output reg              cmd_ready,
  output reg              reply_valid,
  output reg  [7:0]       reply_status,
  output reg  [7:0]       reply_instr,
  output reg  [31:0]      reply_value,
  output reg  [31:0]      accumulator,
  output reg              flag_zero,
  output reg              flag_equal,
  output reg              flag_greater,
  output reg              flag_lower
);
  localparam ST_IDLE = 1'b0;
  localparam ST_DIV  = 1'b1;

  reg        state;
  reg [31:0] hold_operand;
  reg [3:0]  hold_op;
  reg        hold_direct;
  reg        div_start;
  wire       div_done;
  wire [31:0] div_quo;
  wire [31:0] div_rem;

  reg [31:0] rd_value;
  reg        rd_ok;
  reg [31:0] alu_result;
  reg        alu_ok;
  wire [63:0] product = $signed(accumulator) * $signed(cmd_value);

  // Multi-cycle divide keeps the 32-bit divider off the single-cycle path
  acc_divider #(
    .W(32)
  ) u_div (
    .clk       (clk),
    .rst_n     (rst_n),
    .start     (div_start),
    .dividend  (accumulator),
    .divisor   (hold_operand),
    .done      (div_done),
    .quotient  (div_quo),
    .remainder (div_rem)
  );

  // Input selection by bank and port; digital lines read as 0 or 1
  always @* begin
    rd_value = 32'h00000000;
    rd_ok    = 1'b1;
    if (cmd_bank == `ACC_BANK_DIGITAL) begin
      if (cmd_type < 8'h04)
        rd_value = {31'h00000000, general_input[cmd_type[1:0]]};
      else if (cmd_type == `ACC_PORT_ALL)
        rd_value = {24'h000000, 4'h0, general_input};
      else if (cmd_type == `ACC_PORT_ENC_ZERO)
        rd_value = {31'h00000000, encoder_near_zero};
      else
        rd_ok = 1'b0;
    end else if (cmd_bank == `ACC_BANK_ANALOG) begin
      // Same pin as general_input[0]; both views live side by side
      if (cmd_type == 8'h00)
        rd_value = {{(32-ADC_W){1'b0}}, analog_input_0};
      else if (cmd_type == `ACC_PORT_SUPPLY)
        rd_value = {16'h0000, supply_tenths};
      else if (cmd_type == `ACC_PORT_TEMP)
        rd_value = {{16{temperature_c[15]}}, temperature_c};
      else
        rd_ok = 1'b0;
    end else if (cmd_bank == `ACC_BANK_OUTPUTS) begin
      if (cmd_type < 8'h02)
        rd_value = {31'h00000000, digital_output[cmd_type[0]]};
      else
        rd_ok = 1'b0;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Single-cycle operations; divide and modulo go to the divider
  always @* begin
    alu_result = accumulator;
    alu_ok     = 1'b1;
    case (cmd_type[3:0])
      `ACC_OP_ADD:  alu_result = accumulator + cmd_value;
      `ACC_OP_SUB:  alu_result = accumulator - cmd_value;
      `ACC_OP_MUL:  alu_result = product[31:0];
      `ACC_OP_AND:  alu_result = accumulator & cmd_value;
      `ACC_OP_OR:   alu_result = accumulator | cmd_value;
      `ACC_OP_XOR:  alu_result = accumulator ^ cmd_value;
      `ACC_OP_NOT:  alu_result = ~accumulator;
      `ACC_OP_LOAD: alu_result = cmd_value;
      default:      alu_ok = 1'b0;
    endcase
    if (cmd_type[7:4] != 4'h0)
      alu_ok = 1'b0;
  end

  // Command sequencer; operand arrives already assembled MSB first
  always @(posedge clk) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      cmd_ready    <= 1'b1;
      reply_valid  <= 1'b0;
      reply_status <= 8'h00;
      reply_instr  <= 8'h00;
      reply_value  <= 32'h00000000;
      accumulator  <= `ACC_ACC_RESET;
      flag_zero    <= 1'b0;
      flag_equal   <= 1'b0;
      flag_greater <= 1'b0;
      flag_lower   <= 1'b0;
      hold_operand <= 32'h00000000;
      hold_op      <= 4'h0;
      hold_direct  <= 1'b0;
      div_start    <= 1'b0;
    end else begin
      reply_valid <= 1'b0;
      div_start   <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            reply_instr <= cmd_instr;
            if (cmd_instr == `ACC_INS_GET_INPUT) begin
              reply_valid  <= 1'b1;
              reply_status <= rd_ok ? `ACC_ST_OK : `ACC_ST_BAD_VALUE;
              reply_value  <= rd_value;
              // Accumulator only moves in standalone mode
              if (rd_ok && standalone)
                accumulator <= rd_value;
            end else if (cmd_instr == `ACC_INS_ACC_OP) begin
              if (cmd_type == {4'h0, `ACC_OP_DIV} ||
                  cmd_type == {4'h0, `ACC_OP_MOD}) begin
                // Divide by zero would hang nothing but yields junk
                if (cmd_value == 32'h00000000) begin
                  reply_valid  <= 1'b1;
                  reply_status <= `ACC_ST_BAD_VALUE;
                  reply_value  <= cmd_value;
                end else begin
                  state        <= ST_DIV;
                  cmd_ready    <= 1'b0;
                  hold_operand <= cmd_value;
                  hold_op      <= cmd_type[3:0];
                  hold_direct  <= !standalone;
                  div_start    <= 1'b1;
                end
              end else begin
                reply_valid  <= 1'b1;
                reply_status <= alu_ok ? `ACC_ST_OK : `ACC_ST_BAD_TYPE;
                reply_value  <= cmd_value;
                if (alu_ok)
                  accumulator <= alu_result;
              end
            end else if (cmd_instr == `ACC_INS_COMPARE) begin
              // Signed order; accumulator untouched, type and bank ignored
              flag_zero    <= (accumulator == cmd_value);
              flag_equal   <= (accumulator == cmd_value);
              flag_greater <= ($signed(accumulator) >
                               $signed(cmd_value));
              flag_lower   <= ($signed(accumulator) <
                               $signed(cmd_value));
              reply_valid  <= 1'b1;
              reply_status <= `ACC_ST_OK;
              reply_value  <= cmd_value;
            end else begin
              reply_valid  <= 1'b1;
              reply_status <= `ACC_ST_BAD_CMD;
              reply_value  <= 32'h00000000;
            end
          end
        end
        ST_DIV: begin
          if (div_done) begin
            state        <= ST_IDLE;
            cmd_ready    <= 1'b1;
            reply_valid  <= 1'b1;
            reply_status <= `ACC_ST_OK;
            reply_value  <= hold_operand;
            accumulator  <= (hold_op == `ACC_OP_DIV) ?
                            div_quo : div_rem;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- test/acc_alu_monitor.sv
// Port checker for the accumulator unit
`timescale 1ns/1ps
module acc_alu_monitor (
  input wire        clk,
  input wire        rst_n,
  input wire        cmd_valid,
  input wire [7:0]  cmd_instr,
  input wire [7:0]  cmd_type,
  input wire [31:0] cmd_value,
  input wire        standalone,
  input wire        cmd_ready,
  input wire        reply_valid,
  input wire [7:0]  reply_status,
  input wire [31:0] reply_value,
  input wire [31:0] accumulator,
  input wire        flag_equal,
  input wire        flag_greater,
  input wire        flag_lower
);
  // Taken commands, split by instruction
  wire tk   = cmd_valid & cmd_ready;
  wire aop  = tk & (cmd_instr == 8'h13);
  wire cmpc = tk & (cmd_instr == 8'h14);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_cmp_reply;
    cmpc |=> reply_valid && reply_status == 8'h64
      && reply_value == $past(cmd_value);
  endproperty
  a_cmp_reply: assert property (p_cmp_reply) else $error("bad reply");
  property p_cmp_keep;
    cmpc |=> accumulator == $past(accumulator)
      && flag_equal == ($past(accumulator) == $past(cmd_value));
  endproperty
  a_cmp_keep: assert property (p_cmp_keep) else $error("bad equal");
  // Signed order: a negative value must rank below any positive one
  property p_cmp_order;
    cmpc |=> flag_greater == ($signed($past(accumulator))
      > $signed($past(cmd_value))) && flag_lower == ($signed(
      $past(accumulator)) < $signed($past(cmd_value)));
  endproperty
  a_cmp_order: assert property (p_cmp_order) else $error("bad order");
  property p_op_echo;
    aop && cmd_type < 8'h03 |=> reply_valid && reply_status == 8'h64
      && reply_value == $past(cmd_value);
  endproperty
  a_op_echo: assert property (p_op_echo) else $error("no echo");
  property p_add;
    aop && cmd_type == 8'h00 |=>
      accumulator == $past(accumulator) + $past(cmd_value);
  endproperty
  a_add: assert property (p_add) else $error("bad sum");
  property p_and;
    aop && cmd_type == 8'h05 |=>
      accumulator == ($past(accumulator) & $past(cmd_value));
  endproperty
  a_and: assert property (p_and) else $error("bad and");
  property p_not;
    aop && cmd_type == 8'h08 |=> accumulator == ~$past(accumulator);
  endproperty
  a_not: assert property (p_not) else $error("bad invert");
  property p_load;
    aop && cmd_type == 8'h09 |=> accumulator == $past(cmd_value);
  endproperty
  a_load: assert property (p_load) else $error("bad load");
  // Divide stalls the command port, then answers within a fixed bound
  property p_div;
    aop && cmd_type == 8'h03 && cmd_value != 32'h0 |=>
      !cmd_ready ##[1:40] reply_valid;
  endproperty
  a_div: assert property (p_div) else $error("divide hangs");
  property p_direct;
    tk && cmd_instr == 8'h0f && !standalone |=>
      accumulator == $past(accumulator);
  endproperty
  a_direct: assert property (p_direct) else $error("acc changed");
endmodule
bind acc_alu acc_alu_monitor i_mon (.clk, .rst_n, .cmd_valid, .cmd_instr,
  .cmd_type, .cmd_value, .standalone, .cmd_ready, .reply_valid,
  .reply_status, .reply_value, .accumulator, .flag_equal, .flag_greater,
  .flag_lower);

//--- test/acc_host.sv
// Host model issuing one command at a time and collecting the reply
`timescale 1ns/1ps
module acc_host (
  input  wire        clk,
  input  wire        cmd_ready,
  input  wire        reply_valid,
  input  wire [7:0]  reply_status,
  input  wire [31:0] reply_value,
  output reg         cmd_valid,
  output reg  [7:0]  cmd_instr,
  output reg  [7:0]  cmd_type,
  output reg  [7:0]  cmd_bank,
  output reg  [31:0] cmd_value
);
  reg [7:0]  st;
  reg [31:0] val;
  reg        got;
  integer    n;
  initial begin
    cmd_valid = 1'b0;
    cmd_instr = 8'h00;
    cmd_type  = 8'h00;
    cmd_bank  = 8'h00;
    cmd_value = 32'h0;
  end
  // Hold the command until an edge with ready high; released type, bank and value flip
  // (instr is kept) so a design that samples late sees garbage, not a friendly copy
  task send(input [7:0] i, input [7:0] t, input [7:0] b, input [31:0] v);
    begin
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_instr <= i;
      cmd_type  <= t;
      cmd_bank  <= b;
      cmd_value <= v;
      @(negedge clk);
      while (!cmd_ready) @(negedge clk);
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_type  <= ~t;
      cmd_bank  <= ~b;
      cmd_value <= ~v;
      got = 1'b0;
      for (n = 0; n < 60 && !got; n = n + 1) begin
        @(negedge clk);
        if (reply_valid === 1'b1) begin
          got = 1'b1;
          st  = reply_status;
          val = reply_value;
        end
      end
    end
  endtask
endmodule

//--- test/accumulator_alu_and_input_readback_bench.sv
// Self-checking bench for the accumulator unit
`timescale 1ns/1ps
module accumulator_alu_and_input_readback_bench;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         standalone = 1'b0;
  reg  [3:0]  general_input = 4'ha;
  reg  [11:0] analog_input_0 = 12'hfff;
  reg  [15:0] supply_tenths = 16'h00f0;
  reg  [15:0] temperature_c = 16'hfffb;
  reg         encoder_near_zero = 1'b1;
  reg  [1:0]  digital_output = 2'h2;
  wire        cmd_valid, cmd_ready, reply_valid, fz, fe, fg, fl;
  wire [7:0]  cmd_instr, cmd_type, cmd_bank, reply_status, reply_instr;
  wire [31:0] cmd_value, reply_value, accumulator;
  reg  [31:0] acc_m;
  reg  [31:0] opv [0:9];
  integer     error_cnt = 0;
  integer     checked = 0;
  integer     cyc = 0;
  integer     k;
  always #25 clk = ~clk;
  acc_alu i_dut (.clk, .rst_n, .cmd_valid, .cmd_instr, .cmd_type, .cmd_bank,
    .cmd_value, .standalone, .general_input, .analog_input_0,
    .supply_tenths, .temperature_c, .encoder_near_zero, .digital_output,
    .cmd_ready, .reply_valid, .reply_status, .reply_instr, .reply_value,
    .accumulator, .flag_zero(fz), .flag_equal(fe), .flag_greater(fg),
    .flag_lower(fl));
  acc_host i_host (.clk, .cmd_ready, .reply_valid, .reply_status,
    .reply_value, .cmd_valid, .cmd_instr, .cmd_type, .cmd_bank, .cmd_value);
  task close_out;
    begin
      if (error_cnt == 0 && checked > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [8*6-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Every command must be answered; a lost reply would hide stale values
  task run(input [7:0] i, input [7:0] t, input [7:0] b, input [31:0] v);
    begin
      i_host.send(i, t, b, v);
      chk("reply", 32'h1, {31'h0, i_host.got});
      chk("instr", {24'h0, i}, {24'h0, reply_instr});
    end
  endtask
  task rd_in(input [7:0] p, input [7:0] b, input [31:0] e);
    begin
      run(8'h0f, p, b, 32'h0);
      chk("input", e, i_host.val);
    end
  endtask
  task t_inputs;
    begin
      for (k = 0; k < 4; k = k + 1)
        rd_in(k[7:0], 8'h00, {31'h0, general_input[k]});
      rd_in(8'h0b, 8'h00, 32'h1);
      rd_in(8'h00, 8'h01, 32'h00000fff);
      rd_in(8'h08, 8'h01, 32'h000000f0);
      rd_in(8'h09, 8'h01, 32'hfffffffb);
      rd_in(8'h00, 8'h02, 32'h0);
      rd_in(8'h01, 8'h02, 32'h1);
      chk("acc", 32'h0, accumulator);
    end
  endtask
  task t_standalone;
    begin
      @(posedge clk);
      general_input <= 4'h5;
      standalone <= 1'b1;
      run(8'h0f, 8'hff, 8'h00, 32'h0);
      chk("acc", 32'h5, accumulator);
      rd_in(8'h09, 8'h01, 32'hfffffffb);
      chk("acc", 32'hfffffffb, accumulator);
      acc_m = 32'hfffffffb;
    end
  endtask
  // Reference result worked out from signed 32-bit arithmetic
  task acc_op(input [7:0] t, input [31:0] v);
    begin
      case (t)
        8'h00: acc_m = acc_m + v;
        8'h01: acc_m = acc_m - v;
        8'h02: acc_m = acc_m * v;
        8'h03: acc_m = $signed(acc_m) / $signed(v);
        8'h04: acc_m = $signed(acc_m) % $signed(v);
        8'h05: acc_m = acc_m & v;
        8'h06: acc_m = acc_m | v;
        8'h07: acc_m = acc_m ^ v;
        8'h08: acc_m = ~acc_m;
        default: acc_m = v;
      endcase
      run(8'h13, t, 8'h00, v);
      chk("acc", acc_m, accumulator);
      chk("echo", v, i_host.val);
      chk("status", 32'h64, {24'h0, i_host.st});
    end
  endtask
  task t_acc_op;
    begin
      @(posedge clk);
      standalone <= 1'b0;
      opv = '{32'd100, 32'd5, 32'd10, 32'hfffffffd, 32'd7, 32'd7, 32'hff,
        32'h100, 32'h1ff, 32'h1234};
      for (k = 0; k < 10; k = k + 1)
        acc_op(8'((k + 9) % 10), opv[k]);
      run(8'h13, 8'h03, 8'h00, 32'h0);
      chk("status", 32'h4, {24'h0, i_host.st});
      chk("acc", acc_m, accumulator);
    end
  endtask
  task cmp(input [31:0] v, input [3:0] e);
    begin
      run(8'h14, 8'h07, 8'h02, v);
      chk("flags", {28'h0, e}, {28'h0, fz, fe, fg, fl});
      chk("acc", acc_m, accumulator);
    end
  endtask
  // Compare is issued from stored-program mode ahead of a jump
  task t_compare;
    begin
      @(posedge clk);
      standalone <= 1'b1;
      acc_op(8'h09, 32'hfffffffe);
      cmp(32'h1, 4'b0001);
      cmp(32'hfffffffe, 4'b1100);
      cmp(32'h80000000, 4'b0010);
    end
  endtask
  // Refused commands: unknown code, bad operation, bad port; no acc change
  task t_errors;
    begin
      run(8'h2a, 8'h00, 8'h00, 32'h0);
      chk("status", 32'h2, {24'h0, i_host.st});
      run(8'h13, 8'h0a, 8'h00, 32'h5);
      chk("status", 32'h3, {24'h0, i_host.st});
      chk("acc", acc_m, accumulator);
      run(8'h0f, 8'h05, 8'h00, 32'h0);
      chk("status", 32'h4, {24'h0, i_host.st});
      chk("acc", acc_m, accumulator);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_inputs;
    t_standalone;
    t_acc_op;
    t_compare;
    t_errors;
    close_out;
  end
  // Hang guard, well above the 150 or so cycles the run needs
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
endmodule
